// >>> verilog/setws_slave.sv
// two-wire serial memory slave front end: conditions, addressing, page write, programming timer
// assumes scl_in is the bus clock, sda_in the resolved bus level, and an external array
// that takes one byte per prog_we_out pulse
//
// Functional notes
// - sample on bus clock rise, drive after fall
// - data line open drain: pull low or release
// - chip select strap static, unconnected reads low
// - write protect high blocks all programming
// - 64 pages of 16 bytes, 10-bit address
// - data changes only while bus clock low
// - data falling while clock high is start
// - data rising while clock high is stop
// - stop after read returns to standby
// - acknowledge each received byte on ninth clock
// - standby after power-up, programming, read end
// - start, eighteen ones, start recovers idle
// - accept only device code 1010
// - fifth bit must match strap, else silent
// - eighth bit one reads, zero writes
// - byte write acked at clocks 9, 18, 27
// - stop after data starts timed programming, busy
// - page write accepts one to sixteen bytes
// - only column bits increment per data byte
// - column wraps, later bytes overwrite earlier
// - no address ack while programming in progress
// - address counter kept between transfers
`timescale 1ns/10ps
`default_nettype none
`include "setws_consts.svh"

module setws_slave #(
	parameter int unsigned PROG_CYCLES = `SETWS_TWC_US * `SETWS_REF_MHZ,
	parameter int unsigned PAGE_BYTES = `SETWS_PAGE_BYTES,
	parameter int unsigned ADDR_BITS = `SETWS_ADDR_BITS
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out_out,
	output logic sda_oe_out,
	input wire logic chip_select_strap_in,
	input wire logic write_protect_in,
	output logic busy_out,
	output logic standby_out,
	output logic prog_we_out,
	output logic [ADDR_BITS-1:0] prog_addr_out,
	output logic [7:0] prog_data_out
);

	localparam int COL_BITS = $clog2(PAGE_BYTES);
	localparam int ROW_BITS = ADDR_BITS - COL_BITS;
	localparam int HI_BITS = ADDR_BITS - 8;
	localparam int TWC_W = $clog2(PROG_CYCLES + 1);
	localparam logic [TWC_W-1:0] TWC_LAST = TWC_W'(PROG_CYCLES - 1);

	// sda edge domain: bus conditions, qualified by the clock level
	logic start_tog_reg;
	logic stop_tog_reg;

	// bus clock domain
	logic [7:0] shift_reg;
	logic start_ack_reg;
	logic [2:0] pin_s1_reg;
	logic [2:0] pin_s2_reg;
	setws_pkg::setws_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic sda_oe_reg;
	logic [HI_BITS-1:0] hi_reg;
	logic [ADDR_BITS-1:0] addr_reg;
	logic pend_reg;
	logic ign_reg;
	logic [PAGE_BYTES-1:0] mask_reg;
	logic [7:0] page_buf [PAGE_BYTES];

	// reference clock domain
	logic [3:0] cond_s1_reg;
	logic [3:0] cond_s2_reg;
	logic [1:0] cond_s3_reg;
	logic frame_reg;
	logic busy_reg;
	logic [TWC_W-1:0] twc_cnt_reg;
	logic [COL_BITS:0] step_reg;
	logic [ROW_BITS-1:0] row_cap_reg;
	logic [PAGE_BYTES-1:0] mask_cap_reg;
	logic prog_we_reg;
	logic [ADDR_BITS-1:0] prog_addr_reg;
	logic [7:0] prog_data_reg;
	logic standby_reg;
	logic sda_low_reg;

	// decoded bus clock domain terms, then decoded reference domain terms
	logic start_seen;
	logic byte_done;
	logic ack_end;
	logic wp_sync;
	logic strap_sync;
	logic busy_sync;
	logic dev_match;
	logic buf_we;
	logic [COL_BITS-1:0] col;
	logic start_evt;
	logic stop_evt;
	logic pend_sync;
	logic ign_sync;

	// start: data falls while the bus clock is high
	always_ff @(negedge sda_in or posedge rst_in) begin
		if (rst_in) begin
			start_tog_reg <= 1'b0;
		end else if (scl_in) begin
			start_tog_reg <= ~start_tog_reg;
		end
	end

	// stop: data rises while the bus clock is high
	always_ff @(posedge sda_in or posedge rst_in) begin
		if (rst_in) begin
			stop_tog_reg <= 1'b0;
		end else if (scl_in) begin
			stop_tog_reg <= ~stop_tog_reg;
		end
	end

	// serial data is latched on the rising bus clock edge
	always_ff @(posedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg <= 8'h00;
		end else begin
			shift_reg <= {shift_reg[6:0], sda_in};
		end
	end

	// static pins and the busy level brought into the bus clock domain
	always_ff @(negedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {busy_reg, chip_select_strap_in, write_protect_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign wp_sync = pin_s2_reg[0];
	assign strap_sync = pin_s2_reg[1];
	assign busy_sync = pin_s2_reg[2];
	assign start_seen = start_tog_reg != start_ack_reg;
	assign byte_done = bit_cnt_reg == `SETWS_LAST_DATA_CNT;
	assign ack_end = bit_cnt_reg == `SETWS_ACK_CNT;
	assign col = addr_reg[COL_BITS-1:0];

	// device code, strap bit and idle array all needed before an ack
	assign dev_match = (shift_reg[`SETWS_CODE_MSB:`SETWS_CODE_LSB] == `SETWS_DEV_CODE)
		&& (shift_reg[`SETWS_STRAP_BIT] == strap_sync)
		&& !busy_sync;

	// a protected write byte is still acked but never reaches the page buffer
	assign buf_we = !start_seen && (state_reg == setws_pkg::ST_DATA) && byte_done && !wp_sync;

	// frame sequencer: runs on the falling edge so the ack changes while the clock is low
	always_ff @(negedge scl_in or posedge rst_in) begin
		if (rst_in) begin
			start_ack_reg <= 1'b0;
			state_reg <= setws_pkg::ST_IDLE;
			bit_cnt_reg <= 4'h0;
			sda_oe_reg <= 1'b0;
			hi_reg <= '0;
			addr_reg <= `SETWS_ADDR_RESET;
			pend_reg <= 1'b0;
			mask_reg <= '0;
			ign_reg <= 1'b0;
		end else begin
			start_ack_reg <= start_tog_reg;
			if (start_seen) begin
				// any start, repeated or after a broken frame, restarts addressing
				state_reg <= setws_pkg::ST_DEV;
				bit_cnt_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
				pend_reg <= 1'b0;
				mask_reg <= '0;
				ign_reg <= 1'b0;
			end else if (state_reg == setws_pkg::ST_IDLE || state_reg == setws_pkg::ST_IGNORE) begin
				sda_oe_reg <= 1'b0;
			end else begin
				bit_cnt_reg <= ack_end ? 4'h0 : bit_cnt_reg + 4'h1;
				if (ack_end) begin
					sda_oe_reg <= 1'b0;
				end
				if (byte_done) begin
					unique case (state_reg)
						setws_pkg::ST_DEV: begin
							if (dev_match) begin
								sda_oe_reg <= 1'b1;
								if (shift_reg[`SETWS_RW_BIT]) begin
									state_reg <= setws_pkg::ST_READ;
								end else begin
									state_reg <= setws_pkg::ST_WADDR;
									hi_reg <= shift_reg[`SETWS_HI_MSB:`SETWS_HI_LSB];
								end
							end else begin
								state_reg <= setws_pkg::ST_IGNORE;
								ign_reg <= 1'b1;
							end
						end
						setws_pkg::ST_WADDR: begin
							addr_reg <= {hi_reg, shift_reg};
							sda_oe_reg <= 1'b1;
							state_reg <= setws_pkg::ST_DATA;
						end
						setws_pkg::ST_DATA: begin
							sda_oe_reg <= 1'b1;
							addr_reg[COL_BITS-1:0] <= col + 1'b1;
							if (!wp_sync) begin
								pend_reg <= 1'b1;
								mask_reg[col] <= 1'b1;
							end
						end
						setws_pkg::ST_READ, setws_pkg::ST_IDLE, setws_pkg::ST_IGNORE: begin
							sda_oe_reg <= 1'b0;
						end
					endcase
				end
			end
		end
	end

	// page buffer, a wrapped column simply overwrites the earlier byte
	always_ff @(negedge scl_in) begin
		if (buf_we) begin
			page_buf[col] <= shift_reg;
		end
	end

	// condition toggles and pending flag into the reference domain
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cond_s1_reg <= 4'h0;
			cond_s2_reg <= 4'h0;
			cond_s3_reg <= 2'h0;
		end else begin
			cond_s1_reg <= {ign_reg, pend_reg, stop_tog_reg, start_tog_reg};
			cond_s2_reg <= cond_s1_reg;
			cond_s3_reg <= cond_s2_reg[1:0];
		end
	end

	assign start_evt = cond_s2_reg[0] ^ cond_s3_reg[0];
	assign stop_evt = cond_s2_reg[1] ^ cond_s3_reg[1];
	assign pend_sync = cond_s2_reg[2];
	assign ign_sync = cond_s2_reg[3];

	// a frame is open from start to stop
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_reg <= 1'b0;
		end else if (stop_evt) begin
			frame_reg <= 1'b0;
		end else if (start_evt) begin
			frame_reg <= 1'b1;
		end
	end

	// self-timed programming; row and mask are stable since the last bus clock edge
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_reg <= 1'b0;
			twc_cnt_reg <= '0;
			step_reg <= '0;
			row_cap_reg <= '0;
			mask_cap_reg <= '0;
		end else if (!busy_reg) begin
			if (stop_evt && pend_sync) begin
				busy_reg <= 1'b1;
				twc_cnt_reg <= '0;
				step_reg <= '0;
				row_cap_reg <= addr_reg[ADDR_BITS-1:COL_BITS];
				mask_cap_reg <= mask_reg;
			end
		end else begin
			twc_cnt_reg <= twc_cnt_reg + 1'b1;
			if (!step_reg[COL_BITS]) begin
				step_reg <= step_reg + 1'b1;
			end
			if (twc_cnt_reg == TWC_LAST) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// one array write per loaded column during the first cycles of programming
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prog_we_reg <= 1'b0;
			prog_addr_reg <= '0;
			prog_data_reg <= 8'h00;
		end else begin
			prog_we_reg <= busy_reg && !step_reg[COL_BITS] && mask_cap_reg[step_reg[COL_BITS-1:0]];
			prog_addr_reg <= {row_cap_reg, step_reg[COL_BITS-1:0]};
			prog_data_reg <= page_buf[step_reg[COL_BITS-1:0]];
		end
	end

	// standby when the array is idle and no frame is open or the open frame is not ours;
	// a refused frame keeps standby until the first bus clock fall of the next start
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			standby_reg <= 1'b1;
			sda_low_reg <= 1'b0;
		end else begin
			standby_reg <= !busy_reg && (!frame_reg || ign_sync);
			sda_low_reg <= 1'b0;
		end
	end

	assign sda_out_out = sda_low_reg;
	assign sda_oe_out = sda_oe_reg;
	assign busy_out = busy_reg;
	assign standby_out = standby_reg;
	assign prog_we_out = prog_we_reg;
	assign prog_addr_out = prog_addr_reg;
	assign prog_data_out = prog_data_reg;

	// bus clock domain checks
	AST_ACK_WADDR: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_WADDR && byte_done) |=> sda_oe_reg ##1 !sda_oe_reg)
		else $error("word address byte not acked for exactly one clock");
	AST_ACK_RELEASE: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && ack_end) |=> !sda_oe_reg)
		else $error("ack held past the ninth clock");
	AST_BAD_CODE: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DEV && byte_done
		&& shift_reg[`SETWS_CODE_MSB:`SETWS_CODE_LSB] != `SETWS_DEV_CODE)
		|=> !sda_oe_reg && state_reg == setws_pkg::ST_IGNORE)
		else $error("wrong device code acked");
	AST_STRAP_MISS: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DEV && byte_done
		&& shift_reg[`SETWS_STRAP_BIT] != strap_sync) |=> state_reg == setws_pkg::ST_IGNORE)
		else $error("strap mismatch not ignored");
	AST_BUSY_NACK: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DEV && byte_done && busy_sync) |=> !sda_oe_reg)
		else $error("address acked while programming");
	AST_READ_DIR: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DEV && byte_done && dev_match
		&& shift_reg[`SETWS_RW_BIT]) |=> state_reg == setws_pkg::ST_READ && sda_oe_reg)
		else $error("read direction not taken");
	AST_COL_ONLY: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DATA && byte_done)
		|=> addr_reg[ADDR_BITS-1:COL_BITS] == $past(addr_reg[ADDR_BITS-1:COL_BITS])
		&& addr_reg[COL_BITS-1:0] == COL_BITS'($past(addr_reg[COL_BITS-1:0]) + 1'b1))
		else $error("page bits moved or column not incremented");
	AST_WP_DISCARD: assert property (@(negedge scl_in) disable iff (rst_in)
		(!start_seen && state_reg == setws_pkg::ST_DATA && byte_done && wp_sync && !pend_reg)
		|=> !pend_reg && sda_oe_reg)
		else $error("protected byte not acked or marked pending");

	// reference domain checks
	AST_PROG_START: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(stop_evt && pend_sync && !busy_reg) |=> busy_reg ##1 busy_reg)
		else $error("programming did not start at stop");
	AST_NO_PROG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(stop_evt && !pend_sync && !busy_reg) |=> !busy_reg)
		else $error("programming started with nothing loaded");
	AST_PROG_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(busy_reg && twc_cnt_reg == TWC_LAST && !frame_reg) |=> !busy_reg ##1 standby_reg)
		else $error("no standby after programming");
	AST_WE_IN_BUSY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		prog_we_out |-> $past(busy_reg) && $past(mask_cap_reg[step_reg[COL_BITS-1:0]]))
		else $error("array write outside a loaded column");

	COV_WRITE_ACK: cover property (@(negedge scl_in) disable iff (rst_in)
		state_reg == setws_pkg::ST_DATA && byte_done ##1 sda_oe_reg);
	COV_POLL_NACK: cover property (@(negedge scl_in) disable iff (rst_in)
		state_reg == setws_pkg::ST_DEV && byte_done && busy_sync);
	COV_WRAP: cover property (@(negedge scl_in) disable iff (rst_in)
		state_reg == setws_pkg::ST_DATA && byte_done && col == '1);
	COV_PROG: cover property (@(posedge ref_clk_in) disable iff (rst_in) $fell(busy_reg));

endmodule : setws_slave

`default_nettype wire

// >>> verilog/setws_consts.svh
// constants for the two-wire serial memory slave front end
// assumes it is included by its bare name from the design files
`ifndef SETWS_CONSTS_SVH
`define SETWS_CONSTS_SVH

// address byte layout, most significant bit first on the wire
`define SETWS_DEV_CODE 4'ha
`define SETWS_CODE_MSB 7
`define SETWS_CODE_LSB 4
`define SETWS_STRAP_BIT 3
`define SETWS_HI_MSB 2
`define SETWS_HI_LSB 1
`define SETWS_RW_BIT 0

// serial framing: bit counter values
`define SETWS_LAST_DATA_CNT 4'h7
`define SETWS_ACK_CNT 4'h8

// array organisation
`define SETWS_PAGE_BYTES 16
`define SETWS_PAGES 64
`define SETWS_ADDR_BITS 10
`define SETWS_ADDR_RESET 10'h000

// programming cycle time in microseconds and reference clock rate in MHz
`define SETWS_TWC_US 5000
`define SETWS_REF_MHZ 100

`endif

// >>> verilog/setws_pkg.sv
// types shared by the two-wire serial memory slave
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package setws_pkg;

	// frame state, gray coded along start -> device byte -> word address -> data
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_DEV = 3'h1,
		ST_WADDR = 3'h3,
		ST_DATA = 3'h2,
		ST_READ = 3'h6,
		ST_IGNORE = 3'h4
	} setws_state_t;

endpackage : setws_pkg

`default_nettype wire

// >>> tb/setws_master_model.sv
// bus master model for the two-wire serial memory slave: start, stop, bits, bytes, recovery
// assumes the bench resolves the data wire with a pull-up and feeds it back on sda_in
`timescale 1ns/10ps
`default_nettype none

module setws_master_model (
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	logic tick_clk;

	// link timing base, 15 ns, unrelated in phase to the reference clock
	initial begin
		tick_clk = 1'b0;
		forever #7.5 tick_clk = ~tick_clk;
	end

	// bus idle: clock high and data released until a frame opens
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	// half a bus clock period
	task automatic half();
		repeat (3) @(posedge tick_clk);
		#1;
	endtask : half

	// start, also a repeated start from clock low
	task automatic start();
		@(posedge tick_clk);
		#1;
		sda_low_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b0;
	endtask : start

	// one bit: data set while clock low, wire sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic s);
		@(posedge tick_clk);
		#1;
		sda_low_out = ~b;
		half();
		scl_out = 1'b1;
		half();
		s = sda_in;
		scl_out = 1'b0;
	endtask : bit_io

	// one byte msb first, then the ninth clock with data released
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send_byte

	// stop, then bus free time before anything else
	task automatic stop();
		@(posedge tick_clk);
		#1;
		sda_low_out = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_low_out = 1'b0;
		half();
		half();
	endtask : stop

	// recovery: start, eighteen ones, start
	task automatic soft_reset();
		logic s;
		start();
		repeat (18) bit_io(1'b1, s);
		start();
	endtask : soft_reset
endmodule : setws_master_model

`default_nettype wire

// >>> tb/test_serial_eeprom_twowire_slave.sv
// self-checking bench for the two-wire serial memory slave
// assumes the master model drives the bus and the array is modelled by a pulse queue
`timescale 1ns/10ps
`default_nettype none

module test_serial_eeprom_twowire_slave;
	localparam int PROG = 300;
	localparam int LIMIT = 40000;
	logic ref_clk_in, rst_in, strap, wp, m_scl, m_low, sda, oe, sda_o, busy, stby, we;
	logic [9:0] paddr;
	logic [7:0] pdata;
	logic [17:0] got_q[$];
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int busy_run = 0;
	int busy_len = 0;
	bit poll_busy = 1'b0;

	// reference clock, 100 MHz
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// wired data line with pull-up
	assign sda = (m_low || (oe && !sda_o)) ? 1'b0 : 1'b1;

	setws_slave #(.PROG_CYCLES(PROG)) setws_slave_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.scl_in(m_scl), .sda_in(sda), .sda_out_out(sda_o), .sda_oe_out(oe),
		.chip_select_strap_in(strap), .write_protect_in(wp), .busy_out(busy), .standby_out(stby),
		.prog_we_out(we), .prog_addr_out(paddr), .prog_data_out(pdata));
	setws_master_model setws_master_model_i (.sda_in(sda), .scl_out(m_scl), .sda_low_out(m_low));

	// collects array write pulses and cuts a hang short
	always @(posedge ref_clk_in) begin
		if (we === 1'b1) begin
			got_q.push_back({paddr, pdata});
		end
		// length of the last programming period in reference cycles
		if (busy === 1'b1) begin
			busy_run++;
		end else if (busy_run != 0) begin
			busy_len = busy_run;
			busy_run = 0;
		end
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : cycles

	// one framed write or address-only command; data bytes are 8'h40 + index
	task automatic wr(input bit fresh, input logic [7:0] dev, input logic [7:0] wa, input int n,
		input logic exp);
		logic a;
		if (fresh) begin
			setws_master_model_i.start();
		end
		setws_master_model_i.send_byte(dev, a);
		check("address ack", 32'(a), 32'(exp));
		check("standby in frame", 32'(stby), 32'(!exp && !poll_busy));
		if (exp === 1'b1 && dev[0] === 1'b0) begin
			setws_master_model_i.send_byte(wa, a);
			check("word ack", 32'(a), 32'h1);
			for (int k = 0; k < n; k++) begin
				setws_master_model_i.send_byte(8'h40 + 8'(k), a);
				check("data ack", 32'(a), 32'h1);
			end
		end
		setws_master_model_i.stop();
	endtask : wr

	// waits out programming and compares the array writes with the loaded page
	task automatic check_prog(input bit on, input logic [5:0] page, input int col0, input int n);
		logic [17:0] exp_q[$];
		logic [7:0] dat [16];
		bit hit [16];
		int w;
		for (int k = 0; k < n; k++) begin
			dat[(col0 + k) % 16] = 8'h40 + 8'(k);
			hit[(col0 + k) % 16] = on;
		end
		for (int c = 0; c < 16; c++) begin
			if (hit[c]) begin
				exp_q.push_back({page, 4'(c), dat[c]});
			end
		end
		w = 0;
		while (busy !== 1'b1 && w < 20) begin
			cycles(1);
			w++;
		end
		check("busy", 32'(busy), 32'(on));
		w = 0;
		while (busy !== 1'b0 && w < PROG + 100) begin
			cycles(1);
			w++;
		end
		cycles(3);
		check("standby", 32'(stby), 32'h1);
		if (on) begin
			check("busy time", 32'(busy_len), 32'(PROG));
		end
		check("write count", 32'(got_q.size()), 32'(exp_q.size()));
		foreach (exp_q[i]) begin
			check("array write", 32'(got_q[i]), 32'(exp_q[i]));
		end
		got_q.delete();
	endtask : check_prog

	// values after power-up
	task automatic t_reset();
		check("standby", 32'(stby), 32'h1);
		check("busy", 32'(busy), 32'h0);
		check("sda drive", 32'(oe), 32'h0);
	endtask : t_reset

	// byte write with upper address bits from the address byte
	task automatic t_byte();
		wr(1'b1, 8'ha4, 8'h5a, 1, 1'b1);
		check_prog(1'b1, 6'h25, 10, 1);
	endtask : t_byte

	// polling: no ack while busy, ack after, read stop goes to standby
	task automatic t_poll();
		wr(1'b1, 8'ha0, 8'h03, 1, 1'b1);
		poll_busy = 1'b1;
		wr(1'b1, 8'ha0, 8'h00, 0, 1'b0);
		poll_busy = 1'b0;
		check_prog(1'b1, 6'h00, 3, 1);
		wp = 1'b1;
		wr(1'b1, 8'ha1, 8'h00, 0, 1'b1);
		cycles(5);
		check("standby", 32'(stby), 32'h1);
		wp = 1'b0;
	endtask : t_poll

	// page write of eighteen bytes starting at column 14
	task automatic t_page();
		wr(1'b1, 8'ha2, 8'h3e, 18, 1'b1);
		check_prog(1'b1, 6'h13, 14, 18);
	endtask : t_page

	// wrong code, strap mismatch, strap match with a dummy write
	task automatic t_refuse();
		logic [9:0] tbl [3] = '{10'h0b0, 10'h0a8, 10'h3a8};
		foreach (tbl[i]) begin
			strap = tbl[i][9];
			wr(1'b1, tbl[i][7:0], 8'h00, 0, tbl[i][8]);
		end
		check_prog(1'b0, 6'h00, 0, 0);
		strap = 1'b0;
	endtask : t_refuse

	// protected write: acked, nothing programmed
	task automatic t_wp();
		wp = 1'b1;
		wr(1'b1, 8'ha0, 8'h10, 2, 1'b1);
		check_prog(1'b0, 6'h01, 0, 2);
		wp = 1'b0;
	endtask : t_wp

	// recovery after a write broken off mid-byte
	task automatic t_soft();
		logic s;
		setws_master_model_i.start();
		setws_master_model_i.send_byte(8'ha0, s);
		setws_master_model_i.send_byte(8'h20, s);
		repeat (4) setws_master_model_i.bit_io(1'b0, s);
		setws_master_model_i.soft_reset();
		wr(1'b0, 8'ha6, 8'hf0, 1, 1'b1);
		check_prog(1'b1, 6'h3f, 0, 1);
	endtask : t_soft

	// reset, then the scenarios in turn
	initial begin
		rst_in = 1'b1;
		strap = 1'b0;
		wp = 1'b0;
		cycles(20);
		rst_in = 1'b0;
		cycles(3);
		t_reset();
		t_byte();
		t_poll();
		t_page();
		t_refuse();
		t_wp();
		t_soft();
		final_report();
	end
endmodule : test_serial_eeprom_twowire_slave

`default_nettype wire
